// File: design/nvt_consts.svh
/*
 * Timing constants of the program/erase sequencer.
 * Assumes inclusion by bare name from design files.
 */
`ifndef NVT_CONSTS_SVH
`define NVT_CONSTS_SVH

// Timebase divider width
`define NVT_DIV_W      8
// Single word program: bus cycles, timebase periods
`define NVT_SW_BUS     25
`define NVT_SW_TB      9
// Consecutive row word: bus cycles, timebase periods
`define NVT_BW_BUS     9
`define NVT_BW_TB      4
// Words in one flash row
`define NVT_ROW_WORDS  32
// Erase lengths in timebase periods
`define NVT_SECT_TB    4000
`define NVT_MASS_TB    20000
// Blank check setup cycles and block sizes in words
`define NVT_BC_SETUP   10
`define NVT_FL_WORDS   32768
`define NVT_EE_WORDS   2048
// Permitted timebase range in kHz, software's duty
`define NVT_TB_MIN_KHZ 150
`define NVT_TB_MAX_KHZ 200

`endif

// File: design/nvt_core.sv
/*
 * Program/erase/blank-check timing sequencer for flash and EEPROM.
 * Assumes the array answers blank_word_in for scan_addr_out in the same cycle,
 * and osc_tick_in is a one-cycle enable synchronous to mclk_in.
 */
`timescale 1ns/10ps
`include "nvt_consts.svh"
module nvt_core #(
	parameter int unsigned P_SECT_TB  = `NVT_SECT_TB,
	parameter int unsigned P_MASS_TB  = `NVT_MASS_TB,
	parameter int unsigned P_FL_WORDS = `NVT_FL_WORDS
) (
	// Clock and reset
	input  wire logic                  mclk_in,
	input  wire logic                  arst_n_in,
	// Oscillator and dividers
	input  wire logic                  osc_tick_in,
	input  wire logic [`NVT_DIV_W-1:0] flash_timebase_divider_in,
	input  wire logic [`NVT_DIV_W-1:0] eeprom_timebase_divider_in,
	// Command
	input  wire logic                  cmd_valid_in,
	input  wire nvt_pkg::nvt_op_t      cmd_op_in,
	input  wire logic                  cmd_eeprom_in,
	output logic                       cmd_ready_out,
	// Array scan
	input  wire logic                  blank_word_in,
	output logic                       scan_en_out,
	output logic [14:0]                scan_addr_out,
	// Status
	output logic                       busy_out,
	output logic                       done_out,
	output logic                       blank_fail_out
);
	import nvt_pkg::*;

	typedef struct packed {
		nvt_state_t  state;
		nvt_op_t     op;
		logic        eeprom;
		logic [4:0]  bus;
		logic [14:0] tb;
		logic [4:0]  words;
		logic        pend;
		logic [14:0] addr;
		logic        scan_en;
		logic        ready;
		logic        busy;
		logic        done;
		logic        fail;
	} nvt_core_st_t;

	nvt_core_st_t st_q;
	nvt_core_st_t st_d;
	logic         accept;
	logic         tick;
	logic [1:0]   restart;
	logic [1:0]   tb_tick;

	// ****************************************
	// Timebase dividers
	// ****************************************
	nvt_tb_if tbl [2] ();

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_tb
			assign tbl[g].osc_tick = osc_tick_in;
			assign tbl[g].divider  = (g == 0) ? flash_timebase_divider_in
			                                  : eeprom_timebase_divider_in;
			assign tbl[g].restart  = restart[g];
			assign tb_tick[g]      = tbl[g].tick;
			nvt_timebase u_tb (
				.mclk_in   (mclk_in),
				.arst_n_in (arst_n_in),
				.tb        (tbl[g])
			);
		end
	endgenerate

	function automatic logic [14:0] last_word(input logic eeprom);
		last_word = eeprom ? 15'(`NVT_EE_WORDS - 1) : 15'(P_FL_WORDS - 1);
	endfunction : last_word

	assign accept = cmd_valid_in && st_q.ready;
	assign tick   = st_q.eeprom ? tb_tick[1] : tb_tick[0];

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		st_d      = st_q;
		st_d.done = 1'b0;
		restart   = 2'h0;
		if (st_q.state != NVT_ST_IDLE && accept)
			st_d.pend = 1'b1;
		case (st_q.state)
			NVT_ST_IDLE:
			begin
				if (accept)
				begin
					st_d.op     = cmd_op_in;
					st_d.eeprom = cmd_eeprom_in;
					st_d.words  = 5'h00;
					st_d.fail   = 1'b0;
					st_d.busy   = 1'b1;
					if (cmd_op_in == NVT_OP_BURST && cmd_eeprom_in)
						st_d.op = NVT_OP_PROG;
					case (cmd_op_in)
						NVT_OP_PROG, NVT_OP_BURST:
						begin
							st_d.state = NVT_ST_SETUP;
							st_d.bus   = 5'(`NVT_SW_BUS - 1);
						end
						NVT_OP_SECT:
						begin
							st_d.state = NVT_ST_TIMED;
							st_d.tb    = 15'(P_SECT_TB - 1);
							restart    = cmd_eeprom_in ? 2'h2 : 2'h1;
						end
						NVT_OP_MASS:
						begin
							st_d.state = NVT_ST_TIMED;
							st_d.tb    = 15'(P_MASS_TB - 1);
							restart    = cmd_eeprom_in ? 2'h2 : 2'h1;
						end
						NVT_OP_BLANK:
						begin
							st_d.state = NVT_ST_SETUP;
							st_d.bus   = 5'(`NVT_BC_SETUP - 1);
							st_d.addr  = 15'h0000;
						end
						default:
						begin
							st_d.state = NVT_ST_IDLE;
							st_d.busy  = 1'b0;
						end
					endcase
				end
			end
			NVT_ST_SETUP:
			begin
				if (st_q.bus != 5'h00)
				begin
					st_d.bus = st_q.bus - 5'h01;
				end
				else if (st_q.op == NVT_OP_BLANK)
				begin
					st_d.state = NVT_ST_SCAN;
				end
				else
				begin
					st_d.state = NVT_ST_TIMED;
					st_d.tb    = (st_q.words == 5'h00) ? 15'(`NVT_SW_TB - 1)
					                                   : 15'(`NVT_BW_TB - 1);
					restart    = st_q.eeprom ? 2'h2 : 2'h1;
				end
			end
			NVT_ST_TIMED:
			begin
				if (tick)
				begin
					if (st_q.tb != 15'h0000)
					begin
						st_d.tb = st_q.tb - 15'h0001;
					end
					else
					begin
						st_d.done = 1'b1;
						if (st_d.pend)
						begin
							st_d.pend  = 1'b0;
							st_d.words = st_q.words + 5'h01;
							st_d.state = NVT_ST_SETUP;
							st_d.bus   = 5'(`NVT_BW_BUS - 1);
						end
						else
						begin
							st_d.state = NVT_ST_IDLE;
							st_d.busy  = 1'b0;
						end
					end
				end
			end
			NVT_ST_SCAN:
			begin
				if (!blank_word_in)
				begin
					st_d.fail  = 1'b1;
					st_d.done  = 1'b1;
					st_d.state = NVT_ST_IDLE;
					st_d.busy  = 1'b0;
				end
				else if (st_q.addr == last_word(st_q.eeprom))
				begin
					st_d.done  = 1'b1;
					st_d.state = NVT_ST_IDLE;
					st_d.busy  = 1'b0;
				end
				else
				begin
					st_d.addr = st_q.addr + 15'h0001;
				end
			end
			default:
			begin
				st_d.state = NVT_ST_IDLE;
				st_d.busy  = 1'b0;
			end
		endcase
		st_d.scan_en = (st_d.state == NVT_ST_SCAN);
		if (st_d.state == NVT_ST_IDLE)
			st_d.ready = 1'b1;
		else
			st_d.ready = (st_d.op == NVT_OP_BURST) && !st_d.pend
			             && (st_d.words < 5'(`NVT_ROW_WORDS - 1));
	end

	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st_q       <= '0;
			st_q.ready <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign cmd_ready_out  = st_q.ready;
	assign scan_en_out    = st_q.scan_en;
	assign scan_addr_out  = st_q.addr;
	assign busy_out       = st_q.busy;
	assign done_out       = st_q.done;
	assign blank_fail_out = st_q.fail;

	// ****************************************
	// Checks
	// ****************************************
	property p_sw_timed;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_SETUP && st_q.bus == 5'h00 && st_q.op != NVT_OP_BLANK
		 && st_q.words == 5'h00) |=> (st_q.state == NVT_ST_TIMED && st_q.tb == 15'h0008);
	endproperty
	a_sw_timed: assert property (p_sw_timed)
		else $error("single word not 9 timebase periods");

	property p_bw_timed;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_SETUP && st_q.bus == 5'h00 && st_q.op != NVT_OP_BLANK
		 && st_q.words != 5'h00) |=> (st_q.state == NVT_ST_TIMED && st_q.tb == 15'h0003);
	endproperty
	a_bw_timed: assert property (p_bw_timed)
		else $error("row word not 4 timebase periods");

	property p_row_next;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_TIMED && tick && st_q.tb == 15'h0000 && st_q.pend)
		|=> (st_q.state == NVT_ST_SETUP && st_q.bus == 5'h08
		     && st_q.words == $past(st_q.words) + 5'h01);
	endproperty
	a_row_next: assert property (p_row_next)
		else $error("row word not 9 bus cycles setup");

	property p_row_limit;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.words == 5'h1f) |-> !st_q.ready || st_q.state == NVT_ST_IDLE;
	endproperty
	a_row_limit: assert property (p_row_limit)
		else $error("more than 32 row words offered");

	property p_no_ee_burst;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.busy && st_q.eeprom) |-> st_q.op != NVT_OP_BURST;
	endproperty
	a_no_ee_burst: assert property (p_no_ee_burst)
		else $error("EEPROM row programming");

	property p_sect;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_IDLE && accept && cmd_op_in == NVT_OP_SECT)
		|=> (st_q.state == NVT_ST_TIMED && st_q.tb == 15'(P_SECT_TB - 1));
	endproperty
	a_sect: assert property (p_sect)
		else $error("sector erase length wrong");

	property p_mass;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_IDLE && accept && cmd_op_in == NVT_OP_MASS)
		|=> (st_q.state == NVT_ST_TIMED && st_q.tb == 15'(P_MASS_TB - 1));
	endproperty
	a_mass: assert property (p_mass)
		else $error("mass erase length wrong");

	property p_bc_setup;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_IDLE && accept && cmd_op_in == NVT_OP_BLANK)
		|=> (st_q.state == NVT_ST_SETUP) [*8] ##1 st_q.state == NVT_ST_SETUP
		    ##1 st_q.state == NVT_ST_SETUP
		    ##1 (st_q.scan_en && st_q.addr == 15'h0000);
	endproperty
	a_bc_setup: assert property (p_bc_setup)
		else $error("blank check setup not 10 cycles");

	property p_bc_fail;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_SCAN && !blank_word_in)
		|=> (done_out && blank_fail_out && !busy_out) ##1 !done_out;
	endproperty
	a_bc_fail: assert property (p_bc_fail)
		else $error("blank check did not stop on non-blank word");

	property p_done;
		@(posedge mclk_in) disable iff (!arst_n_in)
		(st_q.state == NVT_ST_TIMED && tick && st_q.tb == 15'h0000) |=> done_out;
	endproperty
	a_done: assert property (p_done)
		else $error("no completion pulse");
endmodule : nvt_core

// File: design/nvt_pkg.sv
/*
 * Types of the program/erase sequencer.
 * Assumes nvt_consts.svh alongside.
 */
package nvt_pkg;
	typedef enum logic [2:0] {
		NVT_OP_PROG,
		NVT_OP_BURST,
		NVT_OP_SECT,
		NVT_OP_MASS,
		NVT_OP_BLANK
	} nvt_op_t;

	typedef enum logic [1:0] {
		NVT_ST_IDLE,
		NVT_ST_SETUP,
		NVT_ST_TIMED,
		NVT_ST_SCAN
	} nvt_state_t;
endpackage : nvt_pkg

// File: design/nvt_tb_if.sv
/*
 * Link between sequencer core and a timebase divider.
 * Assumes one clock domain, mclk_in.
 */
`timescale 1ns/10ps
interface nvt_tb_if;
	logic       osc_tick;
	logic [7:0] divider;
	logic       restart;
	logic       tick;

	modport core (output osc_tick, output divider, output restart, input tick);
	modport gen  (input osc_tick, input divider, input restart, output tick);
endinterface : nvt_tb_if

// File: design/nvt_timebase.sv
/*
 * Program/erase timebase: divides oscillator ticks by divider+1.
 * Assumes osc_tick is a one-cycle enable synchronous to mclk_in.
 */
`timescale 1ns/10ps
`include "nvt_consts.svh"
module nvt_timebase (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic arst_n_in,
	// Divider link
	nvt_tb_if.gen     tb
);
	typedef struct packed {
		logic [`NVT_DIV_W-1:0] cnt;
		logic                  tick;
	} nvt_tb_st_t;

	nvt_tb_st_t st_q;
	nvt_tb_st_t st_d;

	// ****************************************
	// Divider
	// ****************************************
	always_comb
	begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (tb.restart)
		begin
			st_d.cnt = '0;
		end
		else if (tb.osc_tick)
		begin
			if (st_q.cnt == tb.divider)
			begin
				st_d.cnt  = '0;
				st_d.tick = 1'b1;
			end
			else
			begin
				st_d.cnt = st_q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign tb.tick = st_q.tick;

	property p_tick_from_osc;
		@(posedge mclk_in) disable iff (!arst_n_in)
		st_q.tick |-> $past(tb.osc_tick) && !$past(tb.restart);
	endproperty
	a_tick_from_osc: assert property (p_tick_from_osc)
		else $error("timebase tick without oscillator tick");
endmodule : nvt_timebase

// File: verif/tb_top.sv
/*
 * Self-checking bench for nvt_core: timing of every operation.
 * Assumes design files compiled first; the oscillator ticks every cycle.
 */
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
	import nvt_pkg::*;
	typedef struct packed {
		logic [31:0] cyc;
		logic        fail;
	} nvt_exp_t;
	localparam int unsigned P_SECT = 8;
	localparam int unsigned P_MASS = 16;
	localparam int unsigned P_FLW  = 64;
	logic        mclk_in, arst_n_in, cmd_valid_in, cmd_eeprom_in, blank_word_in;
	logic [7:0]  fl_div, ee_div, d;
	nvt_op_t     cmd_op_in;
	logic        cmd_ready_out, scan_en_out, busy_out, done_out, blank_fail_out;
	logic [14:0] scan_addr_out;
	logic [15:0] bad_addr;
	logic [31:0] seed, cyc, acc;
	int          n_mismatch, comparisons;
	nvt_exp_t    exp_q[$];

	nvt_core #(
		.P_SECT_TB (P_SECT),
		.P_MASS_TB (P_MASS),
		.P_FL_WORDS(P_FLW)
	) i_nvt_core (
		.mclk_in                   (mclk_in),
		.arst_n_in                 (arst_n_in),
		.osc_tick_in               (1'b1),
		.flash_timebase_divider_in (fl_div),
		.eeprom_timebase_divider_in(ee_div),
		.cmd_valid_in              (cmd_valid_in),
		.cmd_op_in                 (cmd_op_in),
		.cmd_eeprom_in             (cmd_eeprom_in),
		.cmd_ready_out             (cmd_ready_out),
		.blank_word_in             (blank_word_in),
		.scan_en_out               (scan_en_out),
		.scan_addr_out             (scan_addr_out),
		.busy_out                  (busy_out),
		.done_out                  (done_out),
		.blank_fail_out            (blank_fail_out)
	);

	// ********************
	// Clock, array, checks
	// ********************
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	always @(posedge mclk_in) cyc <= cyc + 32'h1;

	// One word is not blank, unless bad_addr bit 15 is set
	always @(negedge mclk_in)
		blank_word_in <= bad_addr[15] || (scan_addr_out != bad_addr[14:0]);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	always @(negedge mclk_in)
	begin
		if (arst_n_in === 1'b1 && done_out === 1'b1)
		begin
			if (exp_q.size() == 0)
				`CHK(done_out, 1'b0);
			else
			begin
				`CHK(scan_en_out, 1'b0);
				`CHK(cyc, exp_q[0].cyc);
				`CHK(blank_fail_out, exp_q.pop_front().fail);
			end
		end
	end

	// ********************
	// Drivers
	// ********************
	task automatic issue(input nvt_op_t op, input logic ee);
		int n;
		n = 0;
		cmd_op_in     = op;
		cmd_eeprom_in = ee;
		cmd_valid_in  = 1'b1;
		while (cmd_ready_out !== 1'b1 && n < 100)
		begin
			@(negedge mclk_in);
			n++;
		end
		@(negedge mclk_in);
		acc = cyc;
	endtask : issue

	task automatic run(input nvt_op_t op, input logic ee, input logic [31:0] lat,
			input logic f);
		issue(op, ee);
		exp_q.push_back('{cyc: acc + lat, fail: f});
		repeat (3)
		begin
			@(negedge mclk_in);
			`CHK(cmd_ready_out, 1'b0);
		end
		cmd_valid_in = 1'b0;
	endtask : run

	task automatic burst(input int k);
		logic [31:0] t;
		issue(NVT_OP_BURST, 1'b0);
		t = acc + 26 + 9 * (fl_div + 1);
		for (int i = 0; i < k; i++)
		begin
			exp_q.push_back('{cyc: t, fail: 1'b0});
			t = t + 10 + 4 * (fl_div + 1);
		end
		for (int i = 1; i < k; i++)
			issue(NVT_OP_BURST, 1'b0);
		if (k == 32)
			repeat (3)
			begin
				@(negedge mclk_in);
				`CHK(cmd_ready_out, 1'b0);
			end
		cmd_valid_in = 1'b0;
	endtask : burst

	task automatic settle(input string name);
		int n;
		n = 0;
		while ((exp_q.size() != 0 || busy_out !== 1'b0) && n < 20000)
		begin
			@(negedge mclk_in);
			n++;
		end
		`CHK(exp_q.size(), 0);
		$display("test %s done", name);
	endtask : settle

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	initial
	begin
		repeat (60000) @(posedge mclk_in);
		n_mismatch++;
		wrap_up();
	end

	// ********************
	// Tests
	// ********************
	initial
	begin
		seed          = 32'h0d361582;
		cyc           = 32'h0;
		arst_n_in     = 1'b0;
		cmd_valid_in  = 1'b0;
		cmd_op_in     = NVT_OP_PROG;
		cmd_eeprom_in = 1'b0;
		blank_word_in = 1'b1;
		bad_addr      = 16'hffff;
		fl_div        = 8'h0;
		ee_div        = 8'h0;
		n_mismatch    = 0;
		comparisons   = 0;
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		`CHK(cmd_ready_out, 1'b1);
		`CHK(busy_out, 1'b0);
		arst_n_in = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			fl_div = 8'(rnd() % 4);
			ee_div = 8'(rnd() % 4) + 8'h4;
			d = i[0] ? ee_div : fl_div;
			run(NVT_OP_PROG, i[0], 26 + 9 * (d + 1), 1'b0);
			settle("prog");
		end
		fl_div = 8'hff;
		run(NVT_OP_PROG, 1'b0, 26 + 9 * 256, 1'b0);
		settle("slow timebase");
		fl_div = 8'(rnd() % 4);
		for (int i = 0; i < 2; i++)
		begin
			d = i[0] ? ee_div : fl_div;
			run(NVT_OP_SECT, i[0], P_SECT * (d + 1) + 1, 1'b0);
			run(NVT_OP_MASS, i[0], P_MASS * (d + 1) + 1, 1'b0);
			settle("erase");
		end
		bad_addr = 16'h0;
		run(NVT_OP_BLANK, 1'b0, 11, 1'b1);
		settle("blank first word");
		bad_addr = 16'(rnd() % (P_FLW - 2)) + 16'h1;
		run(NVT_OP_BLANK, 1'b0, 11 + bad_addr, 1'b1);
		settle("blank fail");
		bad_addr = 16'hffff;
		run(NVT_OP_BLANK, 1'b0, 10 + P_FLW, 1'b0);
		run(NVT_OP_BLANK, 1'b1, 10 + 2048, 1'b0);
		settle("blank pass");
		burst(2);
		settle("short row");
		burst(32);
		settle("full row");
		run(NVT_OP_BURST, 1'b1, 26 + 9 * (ee_div + 1), 1'b0);
		settle("eeprom row");
		wrap_up();
	end
endmodule : tb_top
